// File: sim/imp_link_chk.sv
// Assertions on the downstream slot link between master port and slave end
`timescale 1ns/1ps
`include "imp_cfg.svh"
module imp_link_chk #(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 32
) (
    input wire logic                    clk,
    input wire logic                    arst_n,
    input wire logic                    slot_reset_out_n,
    input wire logic [ADDR_W-1:0]       ar_addr,
    input wire logic [`IMP_LEN_W-1:0]   ar_len,
    input wire logic [`IMP_BURST_W-1:0] ar_burst,
    input wire logic [`IMP_LOCK_W-1:0]  ar_lock,
    input wire logic                    ar_valid,
    input wire logic                    ar_ready,
    input wire logic [DATA_W-1:0]       r_data,
    input wire logic                    r_last,
    input wire logic                    r_valid,
    input wire logic                    r_ready,
    input wire logic [1:0]              b_resp,
    input wire logic                    b_valid,
    input wire logic                    b_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_ar_hold_payload: assert property (ar_valid && !ar_ready |=> ar_valid && $stable({ar_addr, ar_len}))
        else $error("read address moved while stalled");
    chk_r_hold_payload: assert property (r_valid && !r_ready |=> r_valid && $stable({r_data, r_last}))
        else $error("read data moved while stalled");
    chk_b_hold_resp: assert property (b_valid && !b_ready |=> b_valid && $stable(b_resp))
        else $error("write response moved while stalled");
    chk_burst_in_range: assert property (ar_valid |-> ar_burst <= `IMP_BURST_MAX)
        else $error("burst type out of range");
    chk_lock_in_range: assert property (ar_valid |-> ar_lock <= `IMP_LOCK_MAX)
        else $error("lock type out of range");
    // One slice entry, so an accepted address leaves a gap
    chk_ar_single_slot: assert property (ar_valid && ar_ready |=> !ar_valid)
        else $error("address valid stayed after handshake");
    chk_r_beat_gap: assert property (r_valid && r_ready |=> !r_valid)
        else $error("read valid stayed after handshake");
    chk_slot_reset_sync: assert property ($rose(arst_n) |-> !slot_reset_out_n [*2] ##1 slot_reset_out_n)
        else $error("slot reset release not two edges late");
    cov_burst_addr: cover property (ar_valid && ar_ready && ar_len != 8'h00);
    cov_last_beat: cover property (r_valid && r_ready && r_last);
    cov_err_resp: cover property (b_valid && b_ready && b_resp != 2'h0);
    cov_ar_stall: cover property (ar_valid && !ar_ready);
endmodule

// File: sim/imp_master_port_tb_top.sv
// Testbench: master port facing slave end, and a Lite port facing bench-made faults
`timescale 1ns/1ps
`include "imp_cfg.svh"
module imp_master_port_tb_top;
    import imp_pkg::*;
    localparam logic [31:0] MASK = 32'h5A5A_0000;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [1:0]  req_v = 2'h0, req_rdy, dat_v, dat_last, dat_id, dat_user, rsp_v, rsp_id;
    logic [1:0]  dat_resp [2];
    logic [1:0]  rsp_resp [2];
    logic [31:0] dat_data [2];
    logic        rd_dat_ready = 1'b1, wr_rsp_ready = 1'b1, rd_req_id = 1'b0;
    logic [31:0] rd_req_addr = 32'h0, usr_rd_addr, usr_rd_data;
    logic [7:0]  rd_req_len = 8'h0;
    logic [2:0]  rd_req_size = 3'h2, rd_req_prot = 3'h0;
    logic [1:0]  rd_req_burst = 2'h1, rd_req_lock = 2'h0, usr_rd_resp = 2'h0, usr_wr_resp = 2'h0;
    logic [3:0]  rd_req_cache = 4'h3, rd_req_region = 4'h0, rd_req_qos = 4'h0;
    logic        rd_req_user = 1'b0, usr_wr_done = 1'b0, usr_wr_id = 1'b0;
    int          n_mismatch = 0;
    int          num_checks = 0;
    imp_link_if lnk ();
    imp_link_if lnk2 ();
    // Beat data follows the address so order and stepping show up
    assign usr_rd_data = usr_rd_addr ^ MASK;
    always #5 clk = ~clk;
    imp_master_port #(.PROTO(IMP_PROTO_AXI4)) imp_master_port_inst (
        .clk, .arst_n, .lnk(lnk.port), .rd_req_valid(req_v[0]), .rd_req_ready(req_rdy[0]),
        .rd_req_id, .rd_req_addr, .rd_req_len, .rd_req_size, .rd_req_burst, .rd_req_lock,
        .rd_req_cache, .rd_req_prot, .rd_req_region, .rd_req_qos, .rd_req_user,
        .rd_dat_valid(dat_v[0]), .rd_dat_ready, .rd_dat_id(dat_id[0]), .rd_dat_data(dat_data[0]),
        .rd_dat_resp(dat_resp[0]), .rd_dat_last(dat_last[0]), .rd_dat_user(dat_user[0]),
        .wr_rsp_valid(rsp_v[0]), .wr_rsp_ready, .wr_rsp_id(rsp_id[0]), .wr_rsp_resp(rsp_resp[0]));
    imp_master_port #(.PROTO(IMP_PROTO_LITE)) imp_master_port_lite_inst (
        .clk, .arst_n, .lnk(lnk2.port), .rd_req_valid(req_v[1]), .rd_req_ready(req_rdy[1]),
        .rd_req_id, .rd_req_addr, .rd_req_len, .rd_req_size, .rd_req_burst, .rd_req_lock,
        .rd_req_cache, .rd_req_prot, .rd_req_region, .rd_req_qos, .rd_req_user,
        .rd_dat_valid(dat_v[1]), .rd_dat_ready, .rd_dat_id(dat_id[1]), .rd_dat_data(dat_data[1]),
        .rd_dat_resp(dat_resp[1]), .rd_dat_last(dat_last[1]), .rd_dat_user(dat_user[1]),
        .wr_rsp_valid(rsp_v[1]), .wr_rsp_ready, .wr_rsp_id(rsp_id[1]), .wr_rsp_resp(rsp_resp[1]));
    imp_slave_end imp_slave_end_inst (
        .clk, .lnk(lnk.slave), .usr_rd_start(), .usr_rd_addr, .usr_rd_data, .usr_rd_resp,
        .usr_wr_done, .usr_wr_id, .usr_wr_resp, .usr_wr_busy());
    imp_link_chk #(.DATA_W(32), .ADDR_W(32)) imp_link_chk_inst (
        .clk, .arst_n, .slot_reset_out_n(lnk.slot_reset_out_n), .ar_addr(lnk.ar_addr),
        .ar_len(lnk.ar_len), .ar_burst(lnk.ar_burst), .ar_lock(lnk.ar_lock),
        .ar_valid(lnk.ar_valid), .ar_ready(lnk.ar_ready), .r_data(lnk.r_data),
        .r_last(lnk.r_last), .r_valid(lnk.r_valid), .r_ready(lnk.r_ready),
        .b_resp(lnk.b_resp), .b_valid(lnk.b_valid), .b_ready(lnk.b_ready));
    // Bench stands in for a faulty slave on the Lite slot: undriven fields show unknown
    initial begin
        lnk2.ar_ready = 1'b1;
        lnk2.r_valid = 1'b0;
        lnk2.r_id = 1'b1;
        lnk2.r_data = 32'h0;
        lnk2.r_resp = 2'bxx;
        lnk2.r_last = 1'b0;
        lnk2.r_user = 1'bx;
        lnk2.b_valid = 1'b0;
        lnk2.b_id = 1'b1;
        lnk2.b_resp = 2'bxx;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic hang(input string what);
        n_mismatch++;
        $display("[FAIL] %s expected handshake seen none", what);
        test_done();
    endtask
    task automatic rd_req(input int p, input logic id, input logic [31:0] a, input logic [7:0] len,
                          input logic [1:0] bt, input logic [1:0] lk, input logic [3:0] rq);
        int i;
        @(posedge clk);
        req_v[p] <= 1'b1;
        rd_req_id <= id;
        rd_req_addr <= a;
        rd_req_len <= len;
        rd_req_burst <= bt;
        rd_req_lock <= lk;
        rd_req_region <= rq;
        rd_req_qos <= ~rq;
        @(negedge clk);
        for (i = 0; i < 50 && req_rdy[p] !== 1'b1; i++) begin
            @(negedge clk);
        end
        if (i == 50) hang("rd_req_ready");
        @(posedge clk);
        req_v[p] <= 1'b0;
    endtask
    task automatic ar_chk(input logic [31:0] a, input logic [7:0] len, input logic [1:0] bt,
                          input logic [1:0] lk, input logic [3:0] rq);
        int i;
        @(negedge clk);
        for (i = 0; i < 50 && !(lnk.ar_valid === 1'b1 && lnk.ar_ready === 1'b1); i++) begin
            @(negedge clk);
        end
        if (i == 50) hang("ar_valid");
        chk("ar_addr", a, lnk.ar_addr);
        chk("ar_len", len, lnk.ar_len);
        chk("ar_burst", bt, lnk.ar_burst);
        chk("ar_lock", lk, lnk.ar_lock);
        chk("ar_region", rq, lnk.ar_region);
        chk("ar_qos", {28'h0, ~rq}, lnk.ar_qos);
        chk("ar_size", 32'h2, lnk.ar_size);
    endtask
    task automatic rd_get(input int p, input logic [31:0] d, input logic last, input logic id,
                          input logic [1:0] resp);
        int i;
        @(negedge clk);
        for (i = 0; i < 100 && dat_v[p] !== 1'b1; i++) begin
            @(negedge clk);
        end
        if (i == 100) hang("rd_dat_valid");
        chk("rd_dat_data", d, dat_data[p]);
        chk("rd_dat_last", last, dat_last[p]);
        chk("rd_dat_id", id, dat_id[p]);
        chk("rd_dat_resp", resp, dat_resp[p]);
        chk("rd_dat_user", 0, dat_user[p]);
        @(posedge clk);
    endtask
    task automatic wr_get(input int p, input logic id, input logic [1:0] resp);
        int i;
        @(negedge clk);
        for (i = 0; i < 100 && rsp_v[p] !== 1'b1; i++) begin
            @(negedge clk);
        end
        if (i == 100) hang("wr_rsp_valid");
        chk("wr_rsp_id", id, rsp_id[p]);
        chk("wr_rsp_resp", resp, rsp_resp[p]);
        @(posedge clk);
    endtask
    initial begin
        #500000;
        hang("run time");
    end
    initial begin
        int k;
        int i;
        repeat (16) @(posedge clk);
        chk("slot_reset_out_n in reset", 0, lnk.slot_reset_out_n);
        chk("rd_req_ready in reset", 1, req_rdy[0]);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("slot_reset_out_n after", 1, lnk.slot_reset_out_n);
        for (k = 0; k < 4; k++) begin
            usr_rd_resp <= k[1:0];
            rd_req(0, k[0], 32'h100 + 16 * k, 8'h0, 2'h1, 2'h0, k[3:0] + 4'h5);
            ar_chk(32'h100 + 16 * k, 8'h0, 2'h1, 2'h0, k[3:0] + 4'h5);
            rd_get(0, (32'h100 + 16 * k) ^ MASK, 1'b1, k[0], k[1:0]);
        end
        $display("test read response codes done");
        usr_rd_resp <= 2'h0;
        rd_dat_ready <= 1'b0;
        rd_req(0, 1'b1, 32'h400, 8'h3, 2'h3, 2'h3, 4'hF);
        ar_chk(32'h400, 8'h3, 2'h2, 2'h1, 4'hF);
        // Second address waits while the slave is busy with the burst
        rd_req(0, 1'b0, 32'h500, 8'h0, 2'h1, 2'h0, 4'h1);
        repeat (10) @(posedge clk);
        rd_dat_ready <= 1'b1;
        for (k = 0; k < 4; k++) begin
            rd_get(0, (32'h400 + 4 * k) ^ MASK, k == 3, 1'b1, 2'h0);
        end
        rd_get(0, 32'h500 ^ MASK, 1'b1, 1'b0, 2'h0);
        $display("test stalled burst done");
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            usr_wr_done <= 1'b1;
            usr_wr_id <= ~k[0];
            usr_wr_resp <= k[1:0];
            @(posedge clk);
            usr_wr_done <= 1'b0;
            wr_get(0, ~k[0], k[1:0]);
        end
        // Two responses while the consumer stalls: the second waits on the link
        wr_rsp_ready <= 1'b0;
        for (k = 0; k < 2; k++) begin
            @(posedge clk);
            usr_wr_done <= 1'b1;
            usr_wr_id <= k[0];
            usr_wr_resp <= 2'h3 - k[1:0];
            @(posedge clk);
            usr_wr_done <= 1'b0;
        end
        repeat (4) @(posedge clk);
        wr_rsp_ready <= 1'b1;
        wr_get(0, 1'b0, 2'h3);
        wr_get(0, 1'b1, 2'h2);
        $display("test write responses done");
        rd_req(1, 1'b0, 32'h800, 8'h5, 2'h1, 2'h0, 4'h2);
        for (i = 0; i < 50 && lnk2.ar_valid !== 1'b1; i++) begin
            @(negedge clk);
        end
        if (i == 50) hang("lite ar_valid");
        chk("lite ar_len", 0, lnk2.ar_len);
        @(posedge clk);
        lnk2.r_valid <= 1'b1;
        lnk2.r_data <= 32'hC3;
        for (i = 0; i < 50 && lnk2.r_ready !== 1'b1; i++) begin
            @(negedge clk);
        end
        if (i == 50) hang("lite r_ready");
        @(posedge clk);
        lnk2.r_valid <= 1'b0;
        lnk2.r_data <= ~32'hC3;
        rd_get(1, 32'hC3, 1'b1, 1'b0, 2'h0);
        lnk2.b_valid <= 1'b1;
        for (i = 0; i < 50 && lnk2.b_ready !== 1'b1; i++) begin
            @(negedge clk);
        end
        if (i == 50) hang("lite b_ready");
        @(posedge clk);
        lnk2.b_valid <= 1'b0;
        wr_get(1, 1'b0, 2'h0);
        $display("test lite faults done");
        test_done();
    end
endmodule

// File: src/imp_cfg.svh
// Constants for the interconnect master port and its slave end
`ifndef IMP_CFG_SVH
`define IMP_CFG_SVH
`define IMP_RST_MIN_CYCLES 16
`define IMP_RESP_OKAY      2'h0
`define IMP_LOCK_MAX       2'h1
`define IMP_BURST_MAX      2'h2
`define IMP_LEN_W          8
`define IMP_SIZE_W         3
`define IMP_BURST_W        2
`define IMP_LOCK_W         2
`define IMP_REGION_W       4
`define IMP_QOS_W          4
`define IMP_SYNC_STAGES    2
`endif

// File: src/imp_link_if.sv
// Downstream slot link between master port and slave
`timescale 1ns/1ps
`include "imp_cfg.svh"
interface imp_link_if #(
    parameter int id_field_width = 1,
    parameter int DATA_W         = 32,
    parameter int ADDR_W         = 32,
    parameter int USER_W         = 1
);
    logic                     slot_reset_out_n;
    logic [id_field_width-1:0] ar_id;
    logic [ADDR_W-1:0]        ar_addr;
    logic [`IMP_LEN_W-1:0]    ar_len;
    logic [`IMP_SIZE_W-1:0]   ar_size;
    logic [`IMP_BURST_W-1:0]  ar_burst;
    logic [`IMP_LOCK_W-1:0]   ar_lock;
    logic [3:0]               ar_cache;
    logic [2:0]               ar_prot;
    logic [`IMP_REGION_W-1:0] ar_region;
    logic [`IMP_QOS_W-1:0]    ar_qos;
    logic [USER_W-1:0]        ar_user;
    logic                     ar_valid;
    logic                     ar_ready;
    logic [id_field_width-1:0] r_id;
    logic [DATA_W-1:0]        r_data;
    logic [1:0]               r_resp;
    logic                     r_last;
    logic [USER_W-1:0]        r_user;
    logic                     r_valid;
    logic                     r_ready;
    logic [id_field_width-1:0] b_id;
    logic [1:0]               b_resp;
    logic                     b_valid;
    logic                     b_ready;
    modport port (
        output slot_reset_out_n, ar_id, ar_addr, ar_len, ar_size, ar_burst, ar_lock,
        output ar_cache, ar_prot, ar_region, ar_qos, ar_user, ar_valid, r_ready, b_ready,
        input  ar_ready, r_id, r_data, r_resp, r_last, r_user, r_valid, b_id, b_resp, b_valid
    );
    modport slave (
        input  slot_reset_out_n, ar_id, ar_addr, ar_len, ar_size, ar_burst, ar_lock,
        input  ar_cache, ar_prot, ar_region, ar_qos, ar_user, ar_valid, r_ready, b_ready,
        output ar_ready, r_id, r_data, r_resp, r_last, r_user, r_valid, b_id, b_resp, b_valid
    );
endinterface

// File: src/imp_master_port.sv
// Downstream master port of the interconnect, one slot
`timescale 1ns/1ps
`include "imp_cfg.svh"
module imp_master_port
    import imp_pkg::*;
#(
    parameter int         id_field_width = 1,
    parameter int         DATA_W         = 32,
    parameter int         ADDR_W         = 32,
    parameter int         USER_W         = 1,
    parameter imp_proto_t PROTO          = IMP_PROTO_AXI4
) (
    input  wire logic                      clk,
    input  wire logic                      arst_n,
    imp_link_if.port                       lnk,
    input  wire logic                      rd_req_valid,
    output logic                           rd_req_ready,
    input  wire logic [id_field_width-1:0] rd_req_id,
    input  wire logic [ADDR_W-1:0]         rd_req_addr,
    input  wire logic [`IMP_LEN_W-1:0]     rd_req_len,
    input  wire logic [`IMP_SIZE_W-1:0]    rd_req_size,
    input  wire logic [`IMP_BURST_W-1:0]   rd_req_burst,
    input  wire logic [`IMP_LOCK_W-1:0]    rd_req_lock,
    input  wire logic [3:0]                rd_req_cache,
    input  wire logic [2:0]                rd_req_prot,
    input  wire logic [`IMP_REGION_W-1:0]  rd_req_region,
    input  wire logic [`IMP_QOS_W-1:0]     rd_req_qos,
    input  wire logic [USER_W-1:0]         rd_req_user,
    output logic                           rd_dat_valid,
    input  wire logic                      rd_dat_ready,
    output logic [id_field_width-1:0]      rd_dat_id,
    output logic [DATA_W-1:0]              rd_dat_data,
    output logic [1:0]                     rd_dat_resp,
    output logic                           rd_dat_last,
    output logic [USER_W-1:0]              rd_dat_user,
    output logic                           wr_rsp_valid,
    input  wire logic                      wr_rsp_ready,
    output logic [id_field_width-1:0]      wr_rsp_id,
    output logic [1:0]                     wr_rsp_resp
);
    localparam bit IS_LITE = (PROTO == IMP_PROTO_LITE);

    logic [`IMP_SYNC_STAGES-1:0] rst_sync_ff;
    logic                        ar_valid_ff, nxt_ar_valid;
    logic [id_field_width-1:0]   ar_id_ff, nxt_ar_id;
    logic [ADDR_W-1:0]           ar_addr_ff, nxt_ar_addr;
    logic [`IMP_LEN_W-1:0]       ar_len_ff, nxt_ar_len;
    logic [`IMP_SIZE_W-1:0]      ar_size_ff, nxt_ar_size;
    logic [`IMP_BURST_W-1:0]     ar_burst_ff, nxt_ar_burst;
    logic [`IMP_LOCK_W-1:0]      ar_lock_ff, nxt_ar_lock;
    logic [3:0]                  ar_cache_ff, nxt_ar_cache;
    logic [2:0]                  ar_prot_ff, nxt_ar_prot;
    logic [`IMP_REGION_W-1:0]    ar_region_ff, nxt_ar_region;
    logic [`IMP_QOS_W-1:0]       ar_qos_ff, nxt_ar_qos;
    logic [USER_W-1:0]           ar_user_ff, nxt_ar_user;
    logic                        r_valid_ff, nxt_r_valid;
    logic [id_field_width-1:0]   r_id_ff, nxt_r_id;
    logic [DATA_W-1:0]           r_data_ff, nxt_r_data;
    logic [1:0]                  r_resp_ff, nxt_r_resp;
    logic                        r_last_ff, nxt_r_last;
    logic [USER_W-1:0]           r_user_ff, nxt_r_user;
    logic                        b_valid_ff, nxt_b_valid;
    logic [id_field_width-1:0]   b_id_ff, nxt_b_id;
    logic [1:0]                  b_resp_ff, nxt_b_resp;

    // Async assert, sync release; the global reset length is the source's duty
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_ff <= '0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[`IMP_SYNC_STAGES-2:0], 1'b1};
        end
    end
    assign lnk.slot_reset_out_n = rst_sync_ff[`IMP_SYNC_STAGES-1];

    // One-deep register slice per channel; accept only when empty
    assign rd_req_ready = !ar_valid_ff;
    assign lnk.r_ready  = !r_valid_ff;
    assign lnk.b_ready  = !b_valid_ff;

    always_comb begin
        nxt_ar_valid  = ar_valid_ff;
        nxt_ar_id     = ar_id_ff;
        nxt_ar_addr   = ar_addr_ff;
        nxt_ar_len    = ar_len_ff;
        nxt_ar_size   = ar_size_ff;
        nxt_ar_burst  = ar_burst_ff;
        nxt_ar_lock   = ar_lock_ff;
        nxt_ar_cache  = ar_cache_ff;
        nxt_ar_prot   = ar_prot_ff;
        nxt_ar_region = ar_region_ff;
        nxt_ar_qos    = ar_qos_ff;
        nxt_ar_user   = ar_user_ff;
        if (ar_valid_ff && lnk.ar_ready) begin
            nxt_ar_valid = 1'b0;
        end
        if (rd_req_valid && !ar_valid_ff) begin
            nxt_ar_valid  = 1'b1;
            nxt_ar_id     = rd_req_id;
            nxt_ar_addr   = rd_req_addr;
            // Lite is single beat; out-of-range burst and lock are clipped
            nxt_ar_len    = IS_LITE ? '0 : rd_req_len;
            nxt_ar_size   = rd_req_size;
            nxt_ar_burst  = (rd_req_burst > `IMP_BURST_MAX) ? `IMP_BURST_MAX
                                                              : rd_req_burst;
            nxt_ar_lock   = (rd_req_lock > `IMP_LOCK_MAX) ? `IMP_LOCK_MAX
                                                            : rd_req_lock;
            nxt_ar_cache  = rd_req_cache;
            nxt_ar_prot   = rd_req_prot;
            nxt_ar_region = rd_req_region;
            nxt_ar_qos    = rd_req_qos;
            nxt_ar_user   = rd_req_user;
        end
    end

    always_comb begin
        nxt_r_valid = r_valid_ff;
        nxt_r_id    = r_id_ff;
        nxt_r_data  = r_data_ff;
        nxt_r_resp  = r_resp_ff;
        nxt_r_last  = r_last_ff;
        nxt_r_user  = r_user_ff;
        if (r_valid_ff && rd_dat_ready) begin
            nxt_r_valid = 1'b0;
        end
        if (lnk.r_valid && !r_valid_ff) begin
            nxt_r_valid = 1'b1;
            nxt_r_data  = lnk.r_data;
            // Floating resp and user inputs resolve to zero, which is OKAY and empty user
            nxt_r_resp  = ($isunknown(lnk.r_resp)) ? `IMP_RESP_OKAY : lnk.r_resp;
            nxt_r_id    = IS_LITE ? ar_id_ff : lnk.r_id;
            nxt_r_last  = IS_LITE ? 1'b1 : lnk.r_last;
            nxt_r_user  = (IS_LITE || $isunknown(lnk.r_user)) ? '0 : lnk.r_user;
        end
    end

    always_comb begin
        nxt_b_valid = b_valid_ff;
        nxt_b_id    = b_id_ff;
        nxt_b_resp  = b_resp_ff;
        if (b_valid_ff && wr_rsp_ready) begin
            nxt_b_valid = 1'b0;
        end
        if (lnk.b_valid && !b_valid_ff) begin
            nxt_b_valid = 1'b1;
            nxt_b_id    = IS_LITE ? '0 : lnk.b_id;
            nxt_b_resp  = ($isunknown(lnk.b_resp)) ? `IMP_RESP_OKAY : lnk.b_resp;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ar_valid_ff  <= 1'b0;
            ar_id_ff     <= '0;
            ar_addr_ff   <= '0;
            ar_len_ff    <= '0;
            ar_size_ff   <= '0;
            ar_burst_ff  <= '0;
            ar_lock_ff   <= '0;
            ar_cache_ff  <= '0;
            ar_prot_ff   <= '0;
            ar_region_ff <= '0;
            ar_qos_ff    <= '0;
            ar_user_ff   <= '0;
            r_valid_ff   <= 1'b0;
            r_id_ff      <= '0;
            r_data_ff    <= '0;
            r_resp_ff    <= '0;
            r_last_ff    <= 1'b0;
            r_user_ff    <= '0;
            b_valid_ff   <= 1'b0;
            b_id_ff      <= '0;
            b_resp_ff    <= '0;
        end else begin
            ar_valid_ff  <= nxt_ar_valid;
            ar_id_ff     <= nxt_ar_id;
            ar_addr_ff   <= nxt_ar_addr;
            ar_len_ff    <= nxt_ar_len;
            ar_size_ff   <= nxt_ar_size;
            ar_burst_ff  <= nxt_ar_burst;
            ar_lock_ff   <= nxt_ar_lock;
            ar_cache_ff  <= nxt_ar_cache;
            ar_prot_ff   <= nxt_ar_prot;
            ar_region_ff <= nxt_ar_region;
            ar_qos_ff    <= nxt_ar_qos;
            ar_user_ff   <= nxt_ar_user;
            r_valid_ff   <= nxt_r_valid;
            r_id_ff      <= nxt_r_id;
            r_data_ff    <= nxt_r_data;
            r_resp_ff    <= nxt_r_resp;
            r_last_ff    <= nxt_r_last;
            r_user_ff    <= nxt_r_user;
            b_valid_ff   <= nxt_b_valid;
            b_id_ff      <= nxt_b_id;
            b_resp_ff    <= nxt_b_resp;
        end
    end

    assign lnk.ar_valid  = ar_valid_ff;
    assign lnk.ar_id     = ar_id_ff;
    assign lnk.ar_addr   = ar_addr_ff;
    assign lnk.ar_len    = ar_len_ff;
    assign lnk.ar_size   = ar_size_ff;
    assign lnk.ar_burst  = ar_burst_ff;
    assign lnk.ar_lock   = ar_lock_ff;
    assign lnk.ar_cache  = ar_cache_ff;
    assign lnk.ar_prot   = ar_prot_ff;
    assign lnk.ar_region = ar_region_ff;
    assign lnk.ar_qos    = ar_qos_ff;
    assign lnk.ar_user   = ar_user_ff;
    assign rd_dat_valid  = r_valid_ff;
    assign rd_dat_id     = r_id_ff;
    assign rd_dat_data   = r_data_ff;
    assign rd_dat_resp   = r_resp_ff;
    assign rd_dat_last   = r_last_ff;
    assign rd_dat_user   = r_user_ff;
    assign wr_rsp_valid  = b_valid_ff;
    assign wr_rsp_id     = b_id_ff;
    assign wr_rsp_resp   = b_resp_ff;
endmodule

// File: src/imp_pkg.sv
// Types for the interconnect master port and its slave end
package imp_pkg;
    typedef enum logic [1:0] {
        IMP_PROTO_AXI3  = 2'h0,
        IMP_PROTO_AXI4  = 2'h1,
        IMP_PROTO_LITE  = 2'h2
    } imp_proto_t;
    typedef enum logic [1:0] {
        IMP_SL_IDLE = 2'h0,
        IMP_SL_DATA = 2'h1,
        IMP_SL_RESP = 2'h2
    } imp_sl_state_t;
endpackage

// File: src/imp_slave_end.sv
// Slave end of a downstream slot: answers reads, returns write responses
`timescale 1ns/1ps
`include "imp_cfg.svh"
module imp_slave_end
    import imp_pkg::*;
#(
    parameter int         id_field_width = 1,
    parameter int         DATA_W         = 32,
    parameter int         USER_W         = 1,
    parameter imp_proto_t PROTO          = IMP_PROTO_AXI4
) (
    input  wire logic                      clk,
    imp_link_if.slave                      lnk,
    output logic                           usr_rd_start,
    output logic [31:0]                    usr_rd_addr,
    input  wire logic [DATA_W-1:0]         usr_rd_data,
    input  wire logic [1:0]                usr_rd_resp,
    input  wire logic                      usr_wr_done,
    input  wire logic [id_field_width-1:0] usr_wr_id,
    input  wire logic [1:0]                usr_wr_resp,
    output logic                           usr_wr_busy
);
    imp_sl_state_t             st_ff, nxt_st;
    logic [id_field_width-1:0] id_ff, nxt_id;
    logic [`IMP_LEN_W-1:0]     beats_ff, nxt_beats;
    logic [31:0]               addr_ff, nxt_addr;
    logic [DATA_W-1:0]         data_ff, nxt_data;
    logic [1:0]                resp_ff, nxt_resp;
    logic                      bv_ff, nxt_bv;
    logic [id_field_width-1:0] bid_ff, nxt_bid;
    logic [1:0]                bresp_ff, nxt_bresp;
    wire                       rst_n = lnk.slot_reset_out_n;

    always_comb begin
        nxt_st    = st_ff;
        nxt_id    = id_ff;
        nxt_beats = beats_ff;
        nxt_addr  = addr_ff;
        nxt_data  = data_ff;
        nxt_resp  = resp_ff;
        unique case (st_ff)
            IMP_SL_IDLE: begin
                if (lnk.ar_valid) begin
                    nxt_st    = IMP_SL_DATA;
                    nxt_id    = lnk.ar_id;
                    nxt_beats = lnk.ar_len;
                    nxt_addr  = 32'(lnk.ar_addr);
                end
            end
            IMP_SL_DATA: begin
                // Data sampled in the same cycle as the user start pulse
                nxt_st   = IMP_SL_RESP;
                nxt_data = usr_rd_data;
                nxt_resp = usr_rd_resp;
            end
            IMP_SL_RESP: begin
                if (lnk.r_ready) begin
                    if (beats_ff == '0) begin
                        nxt_st = IMP_SL_IDLE;
                    end else begin
                        nxt_st    = IMP_SL_DATA;
                        nxt_beats = beats_ff - 1'b1;
                        nxt_addr  = addr_ff + 32'h4;
                    end
                end
            end
            default: nxt_st = IMP_SL_IDLE;
        endcase
    end

    always_comb begin
        nxt_bv    = bv_ff;
        nxt_bid   = bid_ff;
        nxt_bresp = bresp_ff;
        if (bv_ff && lnk.b_ready) begin
            nxt_bv = 1'b0;
        end
        if (usr_wr_done && !bv_ff) begin
            nxt_bv    = 1'b1;
            nxt_bid   = usr_wr_id;
            nxt_bresp = usr_wr_resp;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff    <= IMP_SL_IDLE;
            id_ff    <= '0;
            beats_ff <= '0;
            addr_ff  <= '0;
            data_ff  <= '0;
            resp_ff  <= '0;
            bv_ff    <= 1'b0;
            bid_ff   <= '0;
            bresp_ff <= '0;
        end else begin
            st_ff    <= nxt_st;
            id_ff    <= nxt_id;
            beats_ff <= nxt_beats;
            addr_ff  <= nxt_addr;
            data_ff  <= nxt_data;
            resp_ff  <= nxt_resp;
            bv_ff    <= nxt_bv;
            bid_ff   <= nxt_bid;
            bresp_ff <= nxt_bresp;
        end
    end

    // Ready, valid, last and id are always driven; master defaults last and id only in Lite mode
    assign lnk.ar_ready = (st_ff == IMP_SL_IDLE);
    assign lnk.r_valid  = (st_ff == IMP_SL_RESP);
    assign lnk.r_id     = id_ff;
    assign lnk.r_last   = (beats_ff == '0);
    assign lnk.r_data   = data_ff;
    assign lnk.r_resp   = resp_ff;
    assign lnk.r_user   = '0;
    assign lnk.b_valid  = bv_ff;
    assign lnk.b_id     = bid_ff;
    assign lnk.b_resp   = bresp_ff;
    assign usr_rd_start = (st_ff == IMP_SL_DATA);
    assign usr_rd_addr  = addr_ff;
    assign usr_wr_busy  = bv_ff;
endmodule
